// *** inc/cpwm_pkg.sv ***
// Shared constants and types for the complementary PWM stage with
// over-current guard.
// Assumes a single 40 MHz system clock that is also the high-speed clock.
package cpwm_pkg;

  // ****************************************************************
  // Register map (APB byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam int             ADDR_W             = 8;
  localparam logic [7:0]     DEAD_CFG_ADDR [2]  = '{8'h00, 8'h04};
  localparam logic [7:0]     PIN_CTRL_ADDR      = 8'h08;
  localparam logic [7:0]     GUARD_CTRL_ADDR [2] = '{8'h0C, 8'h18};
  localparam logic [7:0]     GUARD_CFG_ADDR [2] = '{8'h10, 8'h1C};
  localparam logic [7:0]     DAC_CODE_ADDR [2]  = '{8'h14, 8'h20};
  localparam logic [7:0]     STATUS_ADDR        = 8'h24;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int             DT_K_LSB           = 0;
  localparam int             DT_PRE_LSB         = 3;
  localparam int             PIN_USE_H_BIT      = 0;   // plus 2 per channel
  localparam int             PIN_USE_L_BIT      = 1;
  localparam int             PIN_SRC_B_BIT      = 4;   // plus 1 per channel
  localparam int             GC_MODE_LSB        = 6;
  localparam int             GC_PIN_LSB         = 4;
  localparam int             GF_FLAG_BIT        = 7;
  localparam int             GF_HYST_BIT        = 6;
  localparam int             GF_FILT_LSB        = 0;
  localparam logic [4:0]     DEAD_CFG_RST       = 5'h00;
  localparam logic [5:0]     PIN_CTRL_RST       = 6'h00;
  localparam logic [7:0]     GUARD_CTRL_RST     = 8'h00;
  localparam logic [3:0]     GUARD_CFG_RST      = 4'h0;
  localparam logic [7:0]     DAC_CODE_RST       = 8'h00;
  localparam logic           HIGH_SIDE_IDLE     = 1'b1;
  localparam logic           LOW_SIDE_IDLE      = 1'b0;

  // ****************************************************************
  // Encodings and timing
  // ****************************************************************
  localparam logic [1:0]     MODE_OFF           = 2'h0;
  localparam logic [1:0]     PIN_SENSE_A        = 2'h2;
  localparam logic [1:0]     PIN_SENSE_B        = 2'h3;
  localparam logic [1:0]     FILT_TICK_LAST     = 2'h3;   // filter clock = f_H / 4
  localparam logic [2:0]     FILT_NONE          = 3'h0;

  // Settings handed to the analog guard macro of one channel
  typedef struct packed {
    logic [1:0] mode;
    logic       sense_a;
    logic       sense_b;
    logic       hyst;
    logic [7:0] dac;
  } guard_analog_t;

endpackage : cpwm_pkg

// *** rtl/trip_debounce.sv ***
// Digital debounce filter for one over-current comparator flag.
// Assumes level_in is already synchronised and tick_in is one clock wide.
`timescale 1ns/10ps
module trip_debounce (
  input  wire logic       clk_sys_in,   // f_H
  input  wire logic       reset_in,     // async, active high
  input  wire logic       tick_in,      // filter clock enable pulse
  input  wire logic       enable_in,    // guard channel enabled
  input  wire logic [2:0] filt_sel_in,  // debounce length code
  input  wire logic       level_in,     // synchronised comparator flag
  output logic            flag_out      // filtered trip flag
);
  import cpwm_pkg::*;

  logic [6:0] cnt_r;
  logic [6:0] limit_m1;

  // Code k asks for 2^k whole filter ticks of a steady new level
  assign limit_m1 = 7'((8'h01 << filt_sel_in) - 8'h01);

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      flag_out <= 1'b0;
      cnt_r    <= 7'h00;
    end
    else if (!enable_in)
    begin
      flag_out <= 1'b0;
      cnt_r    <= 7'h00;
    end
    else if (filt_sel_in == FILT_NONE)
    begin
      flag_out <= level_in;                          // [R18]
      cnt_r    <= 7'h00;
    end
    else if (level_in == flag_out)
      cnt_r    <= 7'h00;                             // [R21]
    else if (tick_in)
    begin
      if (cnt_r == limit_m1)
      begin
        flag_out <= level_in;                        // [R21]
        cnt_r    <= 7'h00;
      end
      else
        cnt_r    <= cnt_r + 7'h01;
    end
  end

  a_filter_bypass: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [R18]
    (enable_in && filt_sel_in == FILT_NONE) |=> (flag_out == $past(level_in)))
    else $error("unfiltered flag did not follow comparator");

  a_filter_hold_steady: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [R21]
    (enable_in && filt_sel_in != FILT_NONE && !tick_in) |=> $stable(flag_out))
    else $error("filtered flag changed without a filter tick");

endmodule : trip_debounce

// *** rtl/cpwm_guard.sv ***
// Two-channel complementary PWM output stage with dead time insertion
// and two over-current guard channels, configured over APB.
// Assumes both timer PWM inputs are on clk_sys_in; comparator flags are
// asynchronous and come from the analog guard macro.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/10ps

// Operation
// [R01] Each channel picks its PWM source from timer module A or timer module B.
// [R02] High-side output is active low, low-side output is active high.
// [R03] Dead time only when both high and low outputs of the pair are used.
// [R04] Every PWM edge holds both outputs off for the dead time first.
// [R05] Dead time clock is f_H divided by 1, 2, 4 or 8 per prescale code.
// [R06] Dead time with count code k lasts (k+1) dead time clock periods.
// [R07] Bits 7 to 5 of dead time configuration read zero, writes ignored.
// [R08] A trip forces enabled high sides high and low sides low logically.
// [R09] Each over-current event raises that guard channel's interrupt request.
// [R10] When the trip clears, forced outputs resume the PWM without software.
// [R11] Raw comparator flag is readable and debounced into the trip flag.
// [R12] Debounce filter runs at a quarter of f_H.
// [R13] An 8-bit DAC code register sets the comparator threshold.
// [R14] A hysteresis enable bit per guard channel switches comparator hysteresis.
// [R15] Each guard channel senses from one of two selectable input pins.
// [R16] Software should use non-inverting mode charging, inverting discharging.
// [R17] Per-output enable bits let a guard channel force that output off.
// [R18] Filter code 0 bypasses; code k needs about 2^k stable filter periods.
// [R19] Filtered trip flag reads 1 while over current, else 0.
// [R20] Mode 00 disables the guard; 01, 10, 11 enable it.
// [R21] Filter output changes only after the new level held long enough.
module cpwm_guard (
  input  wire logic                     clk_sys_in,       // f_H, 40 MHz
  input  wire logic                     reset_in,         // async, active high
  input  wire logic                     psel_in,          // APB select
  input  wire logic                     penable_in,       // APB enable
  input  wire logic                     pwrite_in,        // APB write
  input  wire logic [7:0]               paddr_in,         // APB byte address
  input  wire logic [31:0]              pwdata_in,        // APB write data
  output logic      [31:0]              prdata_out,       // APB read data
  output logic                          pready_out,       // APB ready
  output logic                          pslverr_out,      // APB error
  input  wire logic                     timer_a_pwm_in,   // timer module A PWM
  input  wire logic                     timer_b_pwm_in,   // timer module B PWM
  input  wire logic [1:0]               raw_compare_flag_in, // async comparator flags
  output logic      [1:0]               high_side_out,    // active low gate drive
  output logic      [1:0]               low_side_out,     // active high gate drive
  output cpwm_pkg::guard_analog_t [1:0] guard_analog_out, // analog guard settings
  output logic      [1:0]               trip_irq_out      // one-cycle event pulses
);
  import cpwm_pkg::*;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic        wr_en;
  logic        hit_pin;
  logic        hit_status;
  logic [1:0]  hit_dead;
  logic [1:0]  hit_gctrl;
  logic [1:0]  hit_gcfg;
  logic [1:0]  hit_dac;
  logic        addr_hit;
  logic [5:0]  pin_ctrl_r;
  logic [4:0]  dead_cfg   [2];
  logic [7:0]  guard_ctrl [2];
  logic [3:0]  guard_cfg  [2];
  logic [7:0]  dac_code   [2];
  logic [1:0]  raw_flag;
  logic [1:0]  trip;
  logic [1:0]  force_h;
  logic [1:0]  force_l;
  logic [1:0]  filt_tick_cnt_r;
  logic        filt_tick;
  logic [31:0] rd_dead0;
  logic [31:0] rd_dead1;
  logic [31:0] rd_guard0;
  logic [31:0] rd_guard1;

  assign pready_out  = 1'b1;
  assign wr_en       = psel_in & penable_in & pwrite_in;
  assign hit_pin     = (paddr_in == PIN_CTRL_ADDR);
  assign hit_status  = (paddr_in == STATUS_ADDR);
  assign addr_hit    = hit_pin | hit_status | (|hit_dead) | (|hit_gctrl)
                     | (|hit_gcfg) | (|hit_dac);
  // Unmapped addresses answer with an error and read as zero
  assign pslverr_out = psel_in & penable_in & ~addr_hit;

  // Upper bits of each dead time word are never stored, so they read zero
  assign rd_dead0  = hit_dead[0] ? {27'h0, dead_cfg[0]} : 32'h0;      // [R07]
  assign rd_dead1  = hit_dead[1] ? {27'h0, dead_cfg[1]} : 32'h0;      // [R07]
  assign rd_guard0 = hit_gctrl[0] ? {24'h0, guard_ctrl[0]}
                   : hit_gcfg[0]  ? {24'h0, trip[0], guard_cfg[0][3], 3'h0,
                                     guard_cfg[0][2:0]}               // [R19]
                   : hit_dac[0]   ? {24'h0, dac_code[0]} : 32'h0;
  assign rd_guard1 = hit_gctrl[1] ? {24'h0, guard_ctrl[1]}
                   : hit_gcfg[1]  ? {24'h0, trip[1], guard_cfg[1][3], 3'h0,
                                     guard_cfg[1][2:0]}               // [R19]
                   : hit_dac[1]   ? {24'h0, dac_code[1]} : 32'h0;
  assign prdata_out = rd_dead0 | rd_dead1 | rd_guard0 | rd_guard1
                    | (hit_pin ? {26'h0, pin_ctrl_r} : 32'h0)
                    | (hit_status ? {28'h0, trip, raw_flag} : 32'h0);  // [R11]

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      pin_ctrl_r <= PIN_CTRL_RST;
    else if (wr_en && hit_pin)
      pin_ctrl_r <= pwdata_in[5:0];
  end

  // ****************************************************************
  // Filter clock: one tick every fourth f_H cycle
  // ****************************************************************
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      filt_tick_cnt_r <= 2'h0;
    else
      filt_tick_cnt_r <= filt_tick_cnt_r + 2'h1;
  end

  assign filt_tick = (filt_tick_cnt_r == FILT_TICK_LAST);              // [R12]

  a_filter_tick_rate: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [R12]
    filt_tick |=> !filt_tick [*3] ##1 filt_tick)
    else $error("filter tick is not one in four clocks");

  // ****************************************************************
  // Per-channel logic: guard channel i and output pair i
  // ****************************************************************
  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    logic [4:0] dead_r;
    logic [7:0] gctrl_r;
    logic [3:0] gcfg_r;
    logic [7:0] dac_r;
    logic [2:0] sync_r;
    logic       raw_r;
    logic       trip_prev_r;
    logic       irq_r;
    logic       guard_on;
    logic       pwm;
    logic       pwm_prev_r;
    logic       pwm_edge;
    logic       use_h;
    logic       use_l;
    logic       dt_on;
    logic       dt_busy;
    logic [6:0] dt_load;
    logic [6:0] dt_cnt_r;
    logic       h_act;
    logic       l_act;
    logic       hi_pin_r;
    logic       lo_pin_r;
    logic [2:0] k_code;
    logic [1:0] pre_code;

    assign hit_dead[i]  = (paddr_in == DEAD_CFG_ADDR[i]);
    assign hit_gctrl[i] = (paddr_in == GUARD_CTRL_ADDR[i]);
    assign hit_gcfg[i]  = (paddr_in == GUARD_CFG_ADDR[i]);
    assign hit_dac[i]   = (paddr_in == DAC_CODE_ADDR[i]);
    assign dead_cfg[i]   = dead_r;
    assign guard_ctrl[i] = gctrl_r;
    assign guard_cfg[i]  = gcfg_r;
    assign dac_code[i]   = dac_r;

    // Configuration registers
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
      if (reset_in)
      begin
        dead_r  <= DEAD_CFG_RST;
        gctrl_r <= GUARD_CTRL_RST;
        gcfg_r  <= GUARD_CFG_RST;
        dac_r   <= DAC_CODE_RST;
      end
      else if (wr_en)
      begin
        if (hit_dead[i])
          dead_r  <= pwdata_in[4:0];                                  // [R07]
        if (hit_gctrl[i])
          gctrl_r <= pwdata_in[7:0];
        if (hit_gcfg[i])
          gcfg_r  <= {pwdata_in[GF_HYST_BIT], pwdata_in[GF_FILT_LSB +: 3]};
        if (hit_dac[i])
          dac_r   <= pwdata_in[7:0];                                  // [R13]
      end
    end

    // Settings for the analog comparator, DAC and input switches
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
      if (reset_in)
        guard_analog_out[i] <= '0;
      else
      begin
        guard_analog_out[i].mode    <= gctrl_r[GC_MODE_LSB +: 2];       // [R20]
        guard_analog_out[i].sense_a <= (gctrl_r[GC_PIN_LSB +: 2] == PIN_SENSE_A); // [R15]
        guard_analog_out[i].sense_b <= (gctrl_r[GC_PIN_LSB +: 2] == PIN_SENSE_B); // [R15]
        guard_analog_out[i].hyst    <= gcfg_r[3];                      // [R14]
        guard_analog_out[i].dac     <= dac_r;                          // [R13]
      end
    end

    // Comparator flag crossing: a change counts once stages two and three agree
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
      if (reset_in)
      begin
        sync_r <= 3'h0;
        raw_r  <= 1'b0;
      end
      else
      begin
        sync_r <= {sync_r[1:0], raw_compare_flag_in[i]};
        if (sync_r[1] == sync_r[2])
          raw_r <= sync_r[2];
      end
    end

    assign raw_flag[i] = raw_r;                                        // [R11]
    assign guard_on    = (gctrl_r[GC_MODE_LSB +: 2] != MODE_OFF);      // [R20]

    trip_debounce u_debounce (
      .clk_sys_in  (clk_sys_in),
      .reset_in    (reset_in),
      .tick_in     (filt_tick),
      .enable_in   (guard_on),
      .filt_sel_in (gcfg_r[2:0]),
      .level_in    (raw_r),
      .flag_out    (trip[i])                                           // [R11]
    );

    // Rising trip flag is the over-current event
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
      if (reset_in)
      begin
        trip_prev_r <= 1'b0;
        irq_r       <= 1'b0;
      end
      else
      begin
        trip_prev_r <= trip[i];
        irq_r       <= trip[i] & ~trip_prev_r;                         // [R09]
      end
    end

    assign trip_irq_out[i] = irq_r;

    a_guard_off_clears: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [R20]
      !guard_on |=> !trip[i])
      else $error("disabled guard still shows a trip");

    a_irq_on_event: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [R09]
      $rose(trip[i]) |=> trip_irq_out[i] ##1 !trip_irq_out[i])
      else $error("trip event gave no single interrupt pulse");

    // Either guard may force this pair; enable bits sit at 2*i and 2*i+1
    assign force_h[i] = (trip[0] & guard_ctrl[0][2*i])
                      | (trip[1] & guard_ctrl[1][2*i]);                // [R17]
    assign force_l[i] = (trip[0] & guard_ctrl[0][2*i+1])
                      | (trip[1] & guard_ctrl[1][2*i+1]);              // [R17]

    // Output pair with dead time
    assign pwm      = pin_ctrl_r[PIN_SRC_B_BIT + i] ? timer_b_pwm_in
                                                    : timer_a_pwm_in;  // [R01]
    assign use_h    = pin_ctrl_r[PIN_USE_H_BIT + 2*i];
    assign use_l    = pin_ctrl_r[PIN_USE_L_BIT + 2*i];
    assign dt_on    = use_h & use_l;                                   // [R03]
    assign pwm_edge = pwm ^ pwm_prev_r;
    assign k_code   = dead_r[DT_K_LSB +: 3];
    assign pre_code = dead_r[DT_PRE_LSB +: 2];
    // Counting whole f_H cycles gives exactly (k+1) * 2^pre of them
    assign dt_load  = ({4'h0, k_code} + 7'h01) << pre_code;            // [R05] [R06]
    // The new side turns on as the count reaches one, so the gap is N clocks, not N+1
    assign dt_busy  = dt_on & (pwm_edge | (dt_cnt_r > 7'h01));         // [R04] [R06]
    assign l_act    = use_l & pwm & ~dt_busy;
    assign h_act    = use_h & ~pwm & ~dt_busy;

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
      if (reset_in)
      begin
        pwm_prev_r <= 1'b0;
        dt_cnt_r   <= 7'h00;
      end
      else
      begin
        pwm_prev_r <= pwm;
        if (dt_on && pwm_edge)
          dt_cnt_r <= dt_load;                                         // [R04]
        else if (dt_cnt_r != 7'h00)
          dt_cnt_r <= dt_cnt_r - 7'h01;
      end
    end

    // Forcing acts on the logical level, then polarity is applied.
    // Forcing is live every cycle, so outputs recover as soon as trip falls.
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
      if (reset_in)
      begin
        hi_pin_r <= HIGH_SIDE_IDLE;
        lo_pin_r <= LOW_SIDE_IDLE;
      end
      else
      begin
        hi_pin_r <= ~(h_act & ~force_h[i]);                            // [R02] [R08] [R10]
        lo_pin_r <= l_act & ~force_l[i];                               // [R02] [R08] [R10]
      end
    end

    assign high_side_out[i] = hi_pin_r;
    assign low_side_out[i]  = lo_pin_r;

    a_no_overlap: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [R04]
      dt_on |-> !(!high_side_out[i] && low_side_out[i]))
      else $error("both transistors of a pair driven on");

    a_edge_blanks_pair: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [R04]
      (dt_on && pwm_edge) |=> (high_side_out[i] && !low_side_out[i]))
      else $error("output asserted without dead time");

    a_dead_longest: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [R06]
      (dt_on && pwm_edge && dead_r == 5'h1F)
        |=> (dt_cnt_r == 7'h40) ##1 (dt_cnt_r == 7'h3F) [*1] ##62 (dt_cnt_r == 7'h01)
        or ##[0:62] pwm_edge)
      else $error("longest dead time is not 64 clocks");

    a_trip_forces_off: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [R08]
      (force_h[i] && force_l[i]) |=> (high_side_out[i] && !low_side_out[i]))
      else $error("tripped outputs were not forced inactive");

    a_unused_idle: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [R03]
      (!use_h |=> high_side_out[i]) and (!use_l |=> !low_side_out[i]))
      else $error("unused side of a pair was driven on");

    a_low_recovers: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [R10]
      ($fell(force_l[i]) && use_l && !dt_busy) |=> (low_side_out[i] == $past(pwm)))
      else $error("low side did not resume after trip cleared");
  end

endmodule : cpwm_guard

// *** verif/gate_drv_model.sv ***
// Model of the external gate drivers on both complementary pairs.
// Assumes registered gate levels from the stage; counts shoot-through.
`timescale 1ns/10ps
module gate_drv_model (
  input  wire logic       clk_sys_in,   // f_H
  input  wire logic [1:0] high_side_in, // upper gate, on at 0
  input  wire logic [1:0] low_side_in,  // lower gate, on at 1
  output int              overlap_out   // cycles with a pair both on
);
  initial overlap_out = 0;
  // A pair conducting together is a short across the supply
  always @(posedge clk_sys_in)
  begin
    if (|(~high_side_in & low_side_in))
      overlap_out <= overlap_out + 1;
  end
endmodule : gate_drv_model

// *** verif/complementary_pwm_deadtime_ocp_tb.sv ***
// Self-checking bench for the complementary PWM stage with guard.
// Assumes zero-wait APB and the register map of cpwm_pkg.
`timescale 1ns/10ps
module complementary_pwm_deadtime_ocp_tb;
  import cpwm_pkg::*;
  logic                clk_sys_in, reset_in, psel, penable, pwrite;
  logic                pwm_a, pwm_b, err;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, rd, seed;
  logic                pready, pslverr;
  logic [1:0]          raw, hs, ls, irq;
  guard_analog_t [1:0] ga;
  int                  failures, n_tests, ovl, n, k, p;
  logic [7:0]          wa [4] = '{8'h04, 8'h10, 8'h24, 8'h28};
  logic [31:0]         we [4] = '{32'h1F, 32'h47, 32'h0, 32'h0};

  cpwm_guard DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .timer_a_pwm_in(pwm_a), .timer_b_pwm_in(pwm_b), .raw_compare_flag_in(raw),
    .high_side_out(hs), .low_side_out(ls), .guard_analog_out(ga), .trip_irq_out(irq));
  gate_drv_model drv (.clk_sys_in(clk_sys_in), .high_side_in(hs), .low_side_in(ls),
    .overlap_out(ovl));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // ****************************************************************
  // Reference model and checks
  // ****************************************************************
  function automatic int dead_n(input int kk, input int pp);
    return (kk + 1) << pp;
  endfunction : dead_n

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic give_verdict;
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    n_tests++;
    if (g < lo || g > hi)
    begin
      failures++;
      $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  task automatic tick;
    @(posedge clk_sys_in);
    #1;
  endtask : tick

  // Bounded wait; a bit that never arrives ends the run
  task automatic wait_bit(ref logic [1:0] s, input int ch, input logic v, output int c);
    c = 0;
    do
    begin
      tick();
      c++;
    end
    while (s[ch] !== v && c < 300);
    if (s[ch] !== v)
    begin
      failures++;
      give_verdict();
    end
  endtask : wait_bit

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_sys_in);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk_sys_in);
      t++;
    end
    while (pready !== 1'b1 && t < 16);
    if (pready !== 1'b1)
    begin
      failures++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {psel, penable, pwrite, pwm_a, pwm_b} = '0;
    paddr = '0;
    pwdata = '0;
    raw = '0;
    seed = 32'hC138;
    failures = 0;
    n_tests = 0;
    reset_in = 1'b1;
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 11; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", 32'h0, rd);
      chk("slverr", 32'(i == 10), 32'(err));
    end
    // Unimplemented, read-only and unmapped places ignore writes and read zero
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, wa[i], 32'hFFFFFFFF);
      apb(1'b0, wa[i], 32'h0);
      chk("masked readback", we[i], rd);
    end
    apb(1'b1, 8'h10, 32'h0);
    // Single-sided pairs: no dead time, one clock through
    apb(1'b1, PIN_CTRL_ADDR, 32'h29);
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      @(posedge clk_sys_in);
      pwm_a <= seed[0];
      pwm_b <= seed[1];
      tick();
      chk("high side", 32'(pwm_a), 32'(hs[0]));
      chk("low side B", 32'(pwm_b), 32'(ls[1]));
      chk("unused", 32'h2, 32'({hs[1], ls[0]}));
    end
    // Dead time over boundary and random codes
    @(posedge clk_sys_in);
    pwm_a <= 1'b0;
    apb(1'b1, PIN_CTRL_ADDR, 32'h03);
    for (int j = 0; j < 8; j++)
    begin
      seed = lfsr(seed);
      k = (j == 1) ? 7 : (j == 0) ? 0 : int'(seed[2:0]);
      p = (j == 1) ? 3 : (j == 0) ? 0 : int'(seed[4:3]);
      apb(1'b1, DEAD_CFG_ADDR[0], 32'((p << 3) | k));
      wait_bit(hs, 0, 1'b0, n);
      @(posedge clk_sys_in);
      pwm_a <= 1'b1;
      wait_bit(ls, 0, 1'b1, n);
      chk("rise dead", 32'(1 + dead_n(k, p)), 32'(n));
      @(posedge clk_sys_in);
      pwm_a <= 1'b0;
      wait_bit(hs, 0, 1'b0, n);
      chk("fall dead", 32'(1 + dead_n(k, p)), 32'(n));
    end
    // Guard channel 0: no filter, forcing both ch0 outputs
    @(posedge clk_sys_in);
    pwm_a <= 1'b1;
    apb(1'b1, GUARD_CTRL_ADDR[0], 32'h63); // non-inverting while charging
    apb(1'b1, GUARD_CFG_ADDR[0], 32'h40);
    apb(1'b1, DAC_CODE_ADDR[0], 32'hA5);
    wait_bit(ls, 0, 1'b1, n);
    chk("analog", 32'h0DA5, 32'(ga[0]));
    @(posedge clk_sys_in);
    raw[0] <= 1'b1;
    wait_bit(irq, 0, 1'b1, n);
    chk_rng("trip delay", 3, 8, n);
    chk("forced", 32'h1, 32'({ls[0], hs[0]}));
    tick();
    chk("irq pulse", 32'h0, 32'(irq[0]));
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("status", 32'h5, rd);
    apb(1'b0, GUARD_CFG_ADDR[0], 32'h0);
    chk("trip bit", 32'hC0, rd);
    @(posedge clk_sys_in);
    raw[0] <= 1'b0;
    wait_bit(ls, 0, 1'b1, n);
    chk_rng("resume", 3, 10, n);
    // Filter code 3: a short pulse is swallowed, a long one trips in time
    apb(1'b1, GUARD_CFG_ADDR[0], 32'h03);
    @(posedge clk_sys_in);
    raw[0] <= 1'b1;
    repeat (16) @(posedge clk_sys_in);
    raw[0] <= 1'b0;
    n = 0;
    repeat (60)
    begin
      tick();
      n += int'(irq[0]);
    end
    chk("short pulse", 32'h0, 32'(n));
    @(posedge clk_sys_in);
    raw[0] <= 1'b1;
    wait_bit(irq, 0, 1'b1, n);
    chk_rng("filter delay", 4 * 7 + 3, 4 * 8 + 6, n);
    apb(1'b1, GUARD_CTRL_ADDR[0], 32'h33);
    wait_bit(ls, 0, 1'b1, n);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("mode off", 32'h1, rd);
    chk("analog B", 32'h02A5, 32'(ga[0]));
    chk("overlap", 32'h0, 32'(ovl));
    give_verdict();
  end

  initial
  begin
    #2500000;
    failures++;
    give_verdict();
  end
endmodule : complementary_pwm_deadtime_ocp_tb
